/* rtl/ssd_pkg.sv */
// package: register map, fields, timing for the full-duplex synchronous serial port
package ssd_pkg;
  localparam logic [7:0] CTRL_OFS    = 8'h00;
  localparam logic [7:0] STATUS_OFS  = 8'h04;
  localparam logic [7:0] TXBUF_OFS   = 8'h08;
  localparam logic [7:0] RXBUF_OFS   = 8'h0C;
  // control fields
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_FSTOP_BIT = 1;
  localparam int CTRL_ORDER_BIT = 2;
  localparam int CTRL_EXTCK_BIT = 3;
  localparam int CTRL_MODE_LSB  = 4;
  localparam logic [1:0] MODE_TXRX = 2'h2;
  // status fields
  localparam int ST_ACTIVE_BIT = 7;
  localparam int ST_SHIFT_BIT  = 6;
  localparam int ST_TXE_BIT    = 5;
  localparam int ST_RXF_BIT    = 4;
  localparam int ST_TX_UNDERRUN_FLAG_BIT  = 3;
  localparam int ST_RX_OVERRUN_FLAG_BIT  = 2;
  localparam int ST_IRQ_BIT    = 1;
  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam logic [7:0] TXBUF_RESET = 8'hFF;
  localparam logic [7:0] RXBUF_RESET = 8'h00;
  // serial clock half period in system cycles
  localparam int CLK_HZ        = 200_000_000;
  localparam int SCK_HALF_NS   = 250;
  localparam int SCK_HALF_CYC  = (SCK_HALF_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  typedef enum logic [1:0] {SSD_IDLE, SSD_LOAD, SSD_SHIFT, SSD_WAIT} ssd_state_t;
endpackage

/* rtl/ssd_serial.sv */
// full-duplex synchronous serial port with AXI4-Lite register access
`timescale 1ns/1ps
`default_nettype none
module ssd_serial
  import ssd_pkg::*;
#(
  parameter int HALF_CYC = SCK_HALF_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        serial_clock_pin_i,
  output logic             serial_clock_pin_o,
  output logic             serial_clock_pin_oe,
  input  wire logic        serial_in_pin,
  output logic             serial_out_pin,
  output logic             serial_irq
);
  // bus state
  logic        aw_got_q, w_got_q, awready_q, wready_q;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic        bvalid_q, arready_q, rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  bresp_q, rresp_q;
  // control and status
  logic [7:0]  ctrl_q;
  logic        active_q, shiftf_q, txe_q, rxf_q, tx_underrun_flag_q, rx_overrun_flag_q, irq_q;
  logic [7:0]  txbuf_q, rxbuf_q, shreg_q;
  logic [3:0]  bitcnt_q;
  logic        rd_done_q, wr_done_q, loaded_q, pend_rise_q;
  ssd_state_t  state_q;
  // pin synchronisers
  logic        sck_s1_q, sck_s2_q, sck_s3_q, si_s1_q, si_s2_q, si_s3_q;
  // internal clock generator
  logic [15:0] div_q;
  logic        sck_int_q, sck_oe_q;
  logic        sout_q;

  wire         start_bit   = ctrl_q[CTRL_START_BIT];
  wire         lsb_first   = ctrl_q[CTRL_ORDER_BIT];
  wire         ext_clk     = ctrl_q[CTRL_EXTCK_BIT];
  wire         mode_ok     = ctrl_q[CTRL_MODE_LSB +: 2] == MODE_TXRX;
  // write and read decode
  wire         wr_fire     = aw_got_q && w_got_q && !bvalid_q;
  wire         wr_ctrl     = wr_fire && aw_addr_q == CTRL_OFS;
  wire         wr_stat     = wr_fire && aw_addr_q == STATUS_OFS;
  wire         wr_tx       = wr_fire && aw_addr_q == TXBUF_OFS;
  wire         wr_map      = aw_addr_q == CTRL_OFS || aw_addr_q == STATUS_OFS || aw_addr_q == TXBUF_OFS;
  wire         rd_fire     = s_axi_arvalid && arready_q;
  wire         rd_rx       = rd_fire && s_axi_araddr == RXBUF_OFS;
  wire         fstop       = wr_ctrl && w_data_q[CTRL_FSTOP_BIT];
  wire         half_tick   = div_q == 16'(HALF_CYC - 1);
  // serial clock edges, one per domain source
  wire         int_fall    = !ext_clk && half_tick && sck_int_q && state_q == SSD_SHIFT;
  wire         int_rise    = !ext_clk && half_tick && !sck_int_q;
  wire         ext_fall    = ext_clk && sck_s3_q && !sck_s2_q;
  wire         ext_rise    = ext_clk && !sck_s3_q && sck_s2_q;
  wire         fall        = int_fall || ext_fall;
  wire         rise        = int_rise || ext_rise;
  wire         svc_done    = (rd_done_q || rd_rx) && (wr_done_q || wr_tx);
  wire         tx_bit      = lsb_first ? shreg_q[0] : shreg_q[7];
  // external edges are seen late: take data from before the edge
  wire         si_bit      = ext_clk ? si_s3_q : si_s2_q;
  wire [7:0]   shifted     = lsb_first ? {si_bit, shreg_q[7:1]} : {shreg_q[6:0], si_bit};
  wire         last_bit    = bitcnt_q == 4'h8;
  wire         may_start   = start_bit && mode_ok && (ext_clk || !txe_q || loaded_q);
  wire         load_sh     = state_q == SSD_SHIFT && fall && bitcnt_q == 4'h0 && !(txe_q && !loaded_q);
  wire [7:0]   status_rd   = {active_q, shiftf_q, txe_q, rxf_q, tx_underrun_flag_q, rx_overrun_flag_q, irq_q, 1'b0};
  wire [31:0]  rd_mux      = s_axi_araddr == CTRL_OFS   ? {24'h0, ctrl_q} :
                             s_axi_araddr == STATUS_OFS ? {24'h0, status_rd} :
                             s_axi_araddr == RXBUF_OFS  ? {24'h0, rxbuf_q} : 32'h0;
  wire         rd_map      = s_axi_araddr == CTRL_OFS || s_axi_araddr == STATUS_OFS ||
                             s_axi_araddr == RXBUF_OFS || s_axi_araddr == TXBUF_OFS;

  // AXI4-Lite write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q  <= 1'b0;
      w_got_q   <= 1'b0;
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= AXI_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_got_q) begin
        aw_got_q  <= 1'b1;
        awready_q <= 1'b0;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_got_q) begin
        w_got_q  <= 1'b1;
        wready_q <= 1'b0;
        w_data_q <= s_axi_wdata;
      end
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_map ? AXI_OKAY : AXI_SLVERR;
      end
      if (bvalid_q && s_axi_bready) begin
        bvalid_q  <= 1'b0;
        aw_got_q  <= 1'b0;
        w_got_q   <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // AXI4-Lite read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0;
      rresp_q   <= AXI_OKAY;
    end else begin
      arready_q <= !rvalid_q && !arready_q;
      if (rd_fire) begin
        arready_q <= 1'b0;
        rvalid_q  <= 1'b1;
        rdata_q   <= rd_mux;
        rresp_q   <= rd_map ? AXI_OKAY : AXI_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // pin synchronisers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sck_s1_q <= 1'b1;
      sck_s2_q <= 1'b1;
      sck_s3_q <= 1'b1;
      si_s1_q  <= 1'b1;
      si_s2_q  <= 1'b1;
      si_s3_q  <= 1'b1;
    end else begin
      sck_s1_q <= serial_clock_pin_i;
      sck_s2_q <= sck_s1_q;
      sck_s3_q <= sck_s2_q;
      si_s1_q  <= serial_in_pin;
      si_s2_q  <= si_s1_q;
      si_s3_q  <= si_s2_q;
    end
  end

  // internal serial clock divider; idles high outside shifting
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q     <= 16'h0;
      sck_int_q <= 1'b1;
    end else if (fstop || ext_clk || state_q != SSD_SHIFT) begin
      div_q     <= 16'h0;
      sck_int_q <= 1'b1;
    end else begin
      div_q <= half_tick ? 16'h0 : div_q + 16'h1;
      if (half_tick)
        sck_int_q <= !sck_int_q;
    end
  end

  // control register and software access tracking
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q    <= CTRL_RESET;
      sck_oe_q  <= 1'b1;
      rd_done_q <= 1'b0;
      wr_done_q <= 1'b0;
    end else if (fstop) begin
      ctrl_q    <= {w_data_q[7:2], 2'b00};
      sck_oe_q  <= !w_data_q[CTRL_EXTCK_BIT];
      rd_done_q <= 1'b0;
      wr_done_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q   <= {w_data_q[7:2], 1'b0, w_data_q[0]};
        sck_oe_q <= !w_data_q[CTRL_EXTCK_BIT];
      end
      if (state_q == SSD_WAIT && svc_done) begin
        rd_done_q <= 1'b0;
        wr_done_q <= 1'b0;
      end else begin
        // accesses count from the load of the byte in flight
        rd_done_q <= rd_rx || (rd_done_q && !load_sh);
        wr_done_q <= wr_tx || (wr_done_q && !load_sh);
      end
    end
  end

  // transfer engine
  always_ff @(posedge aclk) begin
    if (!aresetn || fstop) begin
      state_q     <= SSD_IDLE;
      active_q    <= 1'b0;
      shiftf_q    <= 1'b0;
      txe_q       <= 1'b1;
      rxf_q       <= 1'b0;
      tx_underrun_flag_q     <= 1'b0;
      rx_overrun_flag_q     <= 1'b0;
      irq_q       <= 1'b0;
      txbuf_q     <= TXBUF_RESET;
      rxbuf_q     <= RXBUF_RESET;
      shreg_q     <= 8'hFF;
      bitcnt_q    <= 4'h0;
      loaded_q    <= 1'b0;
      pend_rise_q <= 1'b0;
      sout_q      <= 1'b1;
    end else begin
      irq_q <= 1'b0;
      if (wr_tx) begin
        txbuf_q  <= w_data_q[7:0];
        txe_q    <= 1'b0;
        loaded_q <= 1'b1;
      end
      if (rd_rx) begin
        rxf_q <= 1'b0;
        if (rx_overrun_flag_q)
          rxbuf_q <= shreg_q;
      end
      if (wr_stat && !w_data_q[ST_TX_UNDERRUN_FLAG_BIT])
        tx_underrun_flag_q <= 1'b0;
      if (wr_stat && !w_data_q[ST_RX_OVERRUN_FLAG_BIT]) begin
        rx_overrun_flag_q <= 1'b0;
        rxf_q   <= 1'b0;
      end
      case (state_q)
        SSD_IDLE: begin
          sout_q <= 1'b1;
          if (may_start)
            state_q <= ext_clk ? SSD_SHIFT : SSD_LOAD;
        end
        SSD_LOAD: begin
          state_q <= SSD_SHIFT;
        end
        SSD_SHIFT: begin
          if (fall && bitcnt_q == 4'h0) begin
            active_q <= 1'b1;
            shiftf_q <= 1'b1;
            bitcnt_q <= 4'h1;
            if (txe_q && !loaded_q) begin
              tx_underrun_flag_q <= 1'b1;
              shreg_q <= shreg_q;
              sout_q  <= 1'b1;
            end else begin
              shreg_q     <= txbuf_q;
              sout_q      <= tx_underrun_flag_q ? 1'b1 : (lsb_first ? txbuf_q[0] : txbuf_q[7]);
              pend_rise_q <= 1'b1;
              loaded_q    <= wr_tx;
            end
          end else if (fall && !last_bit) begin
            bitcnt_q <= bitcnt_q + 4'h1;
            sout_q   <= tx_underrun_flag_q ? 1'b1 : tx_bit;
          end
          if (rise && bitcnt_q != 4'h0) begin
            if (pend_rise_q) begin
              txe_q       <= 1'b1;
              pend_rise_q <= 1'b0;
            end
            if (!rx_overrun_flag_q)
              shreg_q <= shifted;
            if (last_bit) begin
              shiftf_q <= 1'b0;
              bitcnt_q <= 4'h0;
              if (rxf_q && !rx_overrun_flag_q)
                rx_overrun_flag_q <= 1'b1;
              else if (!rx_overrun_flag_q) begin
                rxbuf_q <= shifted;
                rxf_q   <= 1'b1;
                irq_q   <= 1'b1;
              end
              if (!start_bit) begin
                state_q  <= SSD_IDLE;
                active_q <= 1'b0;
              end else if (!ext_clk)
                state_q <= SSD_WAIT;
            end
          end
        end
        SSD_WAIT: begin
          sout_q <= 1'b1;
          if (!start_bit) begin
            state_q  <= SSD_IDLE;
            active_q <= 1'b0;
          end else if (svc_done)
            state_q <= SSD_SHIFT;
        end
        default: state_q <= SSD_IDLE;
      endcase
    end
  end

  // outputs
  assign s_axi_awready       = awready_q;
  assign s_axi_wready        = wready_q;
  assign s_axi_bvalid        = bvalid_q;
  assign s_axi_bresp         = bresp_q;
  assign s_axi_arready       = arready_q;
  assign s_axi_rvalid        = rvalid_q;
  assign s_axi_rdata         = rdata_q;
  assign s_axi_rresp         = rresp_q;
  assign serial_clock_pin_o  = sck_int_q;
  assign serial_clock_pin_oe = sck_oe_q;
  assign serial_out_pin      = sout_q;
  assign serial_irq          = irq_q;

  // checks
  property p_sck_idle;
    @(posedge aclk) disable iff (!aresetn) state_q != SSD_SHIFT |-> ##1 sck_int_q;
  endproperty
  a_sck_idle: assert property (p_sck_idle) else $error("serial clock not idle high");

  property p_txe_clear;
    @(posedge aclk) disable iff (!aresetn) wr_tx && !fstop && !(rise && pend_rise_q) |=> !txe_q;
  endproperty
  a_txe_clear: assert property (p_txe_clear) else $error("empty flag not cleared");

  property p_rx_full;
    @(posedge aclk) disable iff (!aresetn) $rose(rxf_q) |-> irq_q;
  endproperty
  a_rx_full: assert property (p_rx_full) else $error("full without irq");

  property p_underrun_high;
    @(posedge aclk) disable iff (!aresetn) tx_underrun_flag_q && state_q == SSD_SHIFT && bitcnt_q != 4'h0 |-> sout_q;
  endproperty
  a_underrun_high: assert property (p_underrun_high) else $error("out low during underrun");

  property p_overrun_hold;
    @(posedge aclk) disable iff (!aresetn) rx_overrun_flag_q && !rd_rx && !fstop |=> $stable(rxbuf_q);
  endproperty
  a_overrun_hold: assert property (p_overrun_hold) else $error("rx buffer changed in overrun");

  property p_fstop;
    @(posedge aclk) disable iff (!aresetn) fstop |=> !active_q && !ctrl_q[CTRL_START_BIT] && txe_q && !rxf_q;
  endproperty
  a_fstop: assert property (p_fstop) else $error("force stop incomplete");

  property p_idle_out;
    @(posedge aclk) disable iff (!aresetn) state_q == SSD_IDLE ##1 state_q == SSD_IDLE |-> sout_q;
  endproperty
  a_idle_out: assert property (p_idle_out) else $error("out not high when stopped");

  property p_mode;
    @(posedge aclk) disable iff (!aresetn) state_q == SSD_IDLE && !mode_ok |=> state_q == SSD_IDLE;
  endproperty
  a_mode: assert property (p_mode) else $error("started outside full duplex mode");
endmodule // ssd_serial
`default_nettype wire

/* dv/ssd_peer.sv */
// behavioural far-side serial device for the full-duplex port
`timescale 1ns/1ps
`default_nettype none
module ssd_peer (
  input  wire logic sck,
  input  wire logic sout,
  input  wire logic order,
  output var  logic sin,
  output var  logic ext_sck
);
  logic [7:0] p_tx = 8'h00;
  logic [7:0] p_rx = 8'h00;
  int         cnt  = 0;
  initial sin = 1'b1;
  initial ext_sck = 1'b1;
  always @(negedge sck) sin <= p_tx[order ? cnt : 7 - cnt];
  always @(posedge sck) begin
    p_rx[order ? cnt : 7 - cnt] <= sout;
    cnt <= (cnt + 1) % 8;
    // line not held after the frame: show the inverse
    if (cnt == 7) sin <= ~sin;
  end
  // clock stands high outside a frame
  task automatic frame();
    repeat (8) begin
      ext_sck = 1'b0;
      #24;
      ext_sck = 1'b1;
      #24;
    end
  endtask
endmodule // ssd_peer
`default_nettype wire

/* dv/ssd_serial_tb_top.sv */
// self-checking bench for the full-duplex serial port
`timescale 1ns/1ps
`default_nettype none
module ssd_serial_tb_top;
  import ssd_pkg::*;
  localparam logic [33:0] MB = 34'h3000000FF;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, tmp;
  logic        serial_clock_pin_o, serial_clock_pin_oe, serial_in_pin, serial_out_pin, serial_irq;
  logic        ext_sck, ord = 1'b0;
  wire logic   serial_clock_pin_i;
  logic [67:0] rq[$];
  logic [1:0]  bq[$];
  logic [67:0] re;
  logic [7:0]  rnd = 8'h1E, pxb, txb, p1;
  int          bad_count = 0, n_checks = 0, irq_n = 0;

  assign serial_clock_pin_i = serial_clock_pin_oe ? serial_clock_pin_o : ext_sck;
  always #2.5 aclk = ~aclk;

  ssd_serial #(.HALF_CYC(8)) ssd_serial_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .serial_clock_pin_i, .serial_clock_pin_o, .serial_clock_pin_oe, .serial_in_pin, .serial_out_pin, .serial_irq);
  ssd_peer ssd_peer_inst (.sck(serial_clock_pin_i), .sout(serial_out_pin), .order(ord), .sin(serial_in_pin),
    .ext_sck(ext_sck));

  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic check(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tmo(input int n);
    if (n >= 200) begin
      bad_count++;
      finish_test();
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    bq.push_back(er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 200 && (aw || w); n++) begin
      @(posedge aclk);
      if (s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    tmo(n);
    for (n = 0; n < 200 && !s_axi_bvalid; n++) @(posedge aclk);
    tmo(n);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  // mask of zero means poll only, nothing compared
  task automatic axr(input logic [7:0] a, input logic [33:0] e, input logic [33:0] m, output logic [31:0] d);
    int n;
    rq.push_back({m, e});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 200 && !(s_axi_arready && s_axi_arvalid); n++) @(posedge aclk);
    tmo(n);
    s_axi_arvalid <= 1'b0;
    for (n = 0; n < 200 && !s_axi_rvalid; n++) @(posedge aclk);
    tmo(n);
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic poll(input int b, input logic v);
    int n;
    for (n = 0; n < 200; n++) begin
      axr(STATUS_OFS, 34'h0, 34'h0, tmp);
      if (tmp[b] === v) break;
    end
    tmo(n);
  endtask

  task automatic nxt();
    rnd = lfsr(rnd);
    pxb = rnd;
    rnd = lfsr(rnd);
    txb = rnd;
    ssd_peer_inst.p_tx = pxb;
  endtask

  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      re = rq.pop_front();
      if (re[67:34] != 34'h0) check("rdata", {s_axi_rresp, s_axi_rdata} & re[67:34], re[33:0] & re[67:34]);
    end
    if (s_axi_bvalid && s_axi_bready) check("bresp", {32'h0, s_axi_bresp}, {32'h0, bq.pop_front()});
    if (serial_irq) irq_n++;
  end

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    ssd_peer_inst.cnt = 0;
    axr(CTRL_OFS, {AXI_OKAY, 32'h0}, MB, tmp);
    axr(STATUS_OFS, {AXI_OKAY, 32'h20}, 34'h3000000FC, tmp);
    axr(8'h10, {AXI_SLVERR, 32'h0}, 34'h3FFFFFFFF, tmp);
    axw(8'h10, 32'h0, AXI_SLVERR);
    axw(CTRL_OFS, 32'h1, AXI_OKAY);
    axw(TXBUF_OFS, 32'h5A, AXI_OKAY);
    repeat (40) @(posedge aclk);
    axr(STATUS_OFS, {AXI_OKAY, 32'h0}, 34'h3000000E0, tmp);
    axw(CTRL_OFS, 32'h2, AXI_OKAY);
    axr(STATUS_OFS, {AXI_OKAY, 32'h20}, 34'h3000000FC, tmp);
    $display("test reset done");
    for (int o = 0; o < 2; o++) begin
      ord <= o[0];
      axw(CTRL_OFS, {26'h0, MODE_TXRX, 1'b0, o[0], 2'h1}, AXI_OKAY);
      for (int k = 0; k < 2; k++) begin
        nxt();
        axw(TXBUF_OFS, {24'h0, txb}, AXI_OKAY);
        poll(ST_RXF_BIT, 1'b1);
        repeat (20) @(posedge aclk);
        axr(STATUS_OFS, {AXI_OKAY, 32'h10}, 34'h300000050, tmp);
        check("sck_halt", {33'h0, serial_clock_pin_o}, 34'h1);
        if (k == 1) axw(CTRL_OFS, {26'h0, MODE_TXRX, 1'b0, o[0], 2'h0}, AXI_OKAY);
        axr(RXBUF_OFS, {AXI_OKAY, 24'h0, pxb}, MB, tmp);
        check("peer_rx", {26'h0, ssd_peer_inst.p_rx}, {26'h0, txb});
      end
      poll(ST_ACTIVE_BIT, 1'b0);
      check("sck_idle", {33'h0, serial_clock_pin_o}, 34'h1);
      check("sout_idle", {33'h0, serial_out_pin}, 34'h1);
      $display("test internal order %0d done", o);
    end
    check("irq_count", 34'(irq_n), 34'h4);
    ord <= 1'b0;
    axw(CTRL_OFS, {26'h0, MODE_TXRX, 4'h9}, AXI_OKAY);
    nxt();
    axw(TXBUF_OFS, {24'h0, txb}, AXI_OKAY);
    axr(STATUS_OFS, {AXI_OKAY, 32'h0}, 34'h3000000A0, tmp);
    ssd_peer_inst.frame();
    poll(ST_RXF_BIT, 1'b1);
    axr(STATUS_OFS, {AXI_OKAY, 32'hB0}, 34'h3000000FC, tmp);
    check("peer_rx", {26'h0, ssd_peer_inst.p_rx}, {26'h0, txb});
    p1 = pxb;
    nxt();
    ssd_peer_inst.frame();
    poll(ST_RX_OVERRUN_FLAG_BIT, 1'b1);
    axr(STATUS_OFS, {AXI_OKAY, 32'h1C}, 34'h30000001C, tmp);
    check("peer_rx_underrun", {26'h0, ssd_peer_inst.p_rx}, 34'hFF);
    axw(CTRL_OFS, {26'h0, MODE_TXRX, 4'h8}, AXI_OKAY);
    axr(RXBUF_OFS, {AXI_OKAY, 24'h0, p1}, MB, tmp);
    axr(RXBUF_OFS, {AXI_OKAY, 24'h0, pxb}, MB, tmp);
    axw(STATUS_OFS, 32'h0, AXI_OKAY);
    axr(STATUS_OFS, {AXI_OKAY, 32'h0}, 34'h300000014, tmp);
    axw(CTRL_OFS, {26'h0, MODE_TXRX, 4'hA}, AXI_OKAY);
    axr(CTRL_OFS, {AXI_OKAY, 32'h0}, 34'h300000003, tmp);
    axr(STATUS_OFS, {AXI_OKAY, 32'h20}, 34'h3000000FC, tmp);
    axr(RXBUF_OFS, {AXI_OKAY, 24'h0, RXBUF_RESET}, MB, tmp);
    $display("test external errors done");
    finish_test();
  end
endmodule // ssd_serial_tb_top
`default_nettype wire
